// *** design/nvac_top.sv ***
// Functional notes
// - Bit 6 set selects configuration cells, overriding bit 7.
// - Bit 3 flags a write cut short by reset or an improper attempt.
// - A reset abort leaves both space-select bits unchanged.
// - Code protect refuses external reads and writes of data EEPROM.
// - The processor reaches data EEPROM whatever code protect says.
// - Power-up clears the write enable bit.
// - Processor writes to data EEPROM are blocked throughout the power-up timer; external port writes are not.
// - A write starts only with write enable set and the unlock sequence done.
`timescale 1ns/1ps
module nvac_top
  import nvac_pkg::*;
#(
  parameter int unsigned PWRT_COUNT = nvac_pkg::PWRT_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       dev_reset,
  input  wire logic       cp_enable,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata_q,
  input  wire logic       ext_rd,
  input  wire logic       ext_wr,
  input  wire logic [7:0] ext_addr,
  input  wire logic [7:0] ext_wdata,
  output logic      [7:0] ext_rdata_q,
  output logic            ext_ack_q,
  output logic            ext_refused_q,
  output logic            prog_busy_q,
  output logic      [1:0] prog_target_q,
  output logic            prog_erase_q,
  output logic            prog_commit_q,
  output logic      [7:0] prog_addr_q,
  output logic      [7:0] prog_data_q,
  output logic            irq_q
);
  import nvac_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic         space_q;
  logic         cfg_q;
  logic         free_q;
  logic         werr_q;
  logic         wen_q;
  logic         wr_q;
  logic         rd_q;
  logic [7:0]   ee_addr_q;
  logic [7:0]   ee_data_q;
  logic [7:0]   sts_q;
  logic [7:0]   msk_q;
  logic [31:0]  pwrt_cnt_q;
  logic         pwrt_active_q;
  logic [15:0]  wcnt_q;
  logic         rd_pend_q;
  logic         ext_rd_pend_q;
  nvac_unlock_t unl_q;
  nvac_unlock_t unl_d;
  nvac_wstate_t ws_q;

  logic         ctrl_wr;
  logic         key_wr;
  logic         wr_attempt;
  logic         wr_allowed;
  logic         wr_start;
  logic         wr_finish;
  logic         wr_abort;
  logic         rd_start;
  logic         ee_commit;
  logic         ext_go;
  logic         ext_refuse;
  logic [7:0]   ev_set;
  logic         mem_we;
  logic         mem_re;
  logic [7:0]   mem_addr;
  logic [7:0]   mem_wdata;
  logic [7:0]   mem_rdata;
  logic [1:0]   cur_target;

  localparam logic [15:0] WCNT_END = 16'(WRITE_CYCLES - 1);

  // Target chosen by the two space-select bits
  function automatic logic [1:0] target_of(input logic space, input logic cfg);
    if (cfg)
    begin
      target_of = TGT_CONFIG;
    end
    else if (space)
    begin
      target_of = TGT_FLASH;
    end
    else
    begin
      target_of = TGT_EEPROM;
    end
  endfunction

  // ****************************************************************
  // Bus decode and write attempt qualification
  // ****************************************************************
  assign ctrl_wr    = reg_we && (reg_addr == OFS_CTRL);
  assign key_wr     = reg_we && (reg_addr == OFS_KEY);
  assign cur_target = target_of(space_q, cfg_q);
  assign wr_attempt = ctrl_wr && reg_wdata[BIT_WR] && !wr_q && !dev_reset;
  // Needs enable, unlock and, for data EEPROM, an expired power-up timer
  assign wr_allowed = wen_q && (unl_q == UNL_ARMED)
                      && !(pwrt_active_q && (cur_target == TGT_EEPROM));
  assign wr_start   = wr_attempt && wr_allowed;
  assign wr_finish  = (ws_q == WS_BUSY) && (wcnt_q == WCNT_END) && !dev_reset;
  assign wr_abort   = (ws_q == WS_BUSY) && dev_reset;
  assign ee_commit  = wr_finish && (prog_target_q == TGT_EEPROM);
  // Read trigger ignored while either space bit is set
  assign rd_start   = ctrl_wr && reg_wdata[BIT_RD] && !rd_q && !dev_reset
                      && !space_q && !cfg_q;

  // ****************************************************************
  // Memory port sharing: commit, then processor read, then external
  // ****************************************************************
  assign ext_go     = (ext_rd || ext_wr) && !cp_enable && !ee_commit && !rd_start;
  assign ext_refuse = (ext_rd || ext_wr) && !ext_go;
  assign mem_we     = ee_commit || (ext_go && ext_wr);
  assign mem_re     = rd_start || (ext_go && ext_rd && !ext_wr);
  assign mem_addr   = ee_commit ? prog_addr_q : (rd_start ? ee_addr_q : ext_addr);
  assign mem_wdata  = ee_commit ? prog_data_q : ext_wdata;

  nvac_mem u_mem
  (
    .clk     (clk),
    .rst     (rst),
    .we      (mem_we),
    .re      (mem_re),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata_q (mem_rdata)
  );

  // ****************************************************************
  // Power-up timer, started by power-on reset
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pwrt_cnt_q    <= 32'h0000_0000;
      pwrt_active_q <= 1'b1;
    end
    else if (pwrt_active_q)
    begin
      pwrt_cnt_q <= pwrt_cnt_q + 32'h0000_0001;
      if (pwrt_cnt_q >= PWRT_COUNT - 1)
      begin
        pwrt_active_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Unlock key sequence
  // ****************************************************************
  always_comb
  begin
    unl_d = unl_q;
    if (dev_reset || ctrl_wr && reg_wdata[BIT_WR])
    begin
      unl_d = UNL_IDLE; // Each attempt uses up the key
    end
    else if (key_wr)
    begin
      case (unl_q)
        UNL_IDLE:  unl_d = (reg_wdata == KEY_FIRST) ? UNL_GOT1 : UNL_IDLE;
        UNL_GOT1:  unl_d = (reg_wdata == KEY_SECOND) ? UNL_ARMED : UNL_IDLE;
        UNL_ARMED: unl_d = (reg_wdata == KEY_FIRST) ? UNL_GOT1 : UNL_IDLE;
        default:   unl_d = UNL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      unl_q <= UNL_IDLE;
    end
    else
    begin
      unl_q <= unl_d;
    end
  end

  // ****************************************************************
  // Space select, erase select and write enable
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      space_q <= CTRL_RST[BIT_SPACE];
      cfg_q   <= CTRL_RST[BIT_CFG];
      free_q  <= CTRL_RST[BIT_FREE];
      wen_q   <= CTRL_RST[BIT_WEN];
    end
    else if (dev_reset)
    begin
      free_q <= 1'b0;
      wen_q  <= 1'b0;               // Space bits kept for tracing
    end
    else if (ctrl_wr)
    begin
      if (ws_q == WS_IDLE)
      begin
        space_q <= reg_wdata[BIT_SPACE];
        cfg_q   <= reg_wdata[BIT_CFG];
        free_q  <= reg_wdata[BIT_FREE];
      end
      wen_q <= reg_wdata[BIT_WEN];
    end
  end

  // ****************************************************************
  // Write error flag: hardware set wins over a software clear
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      werr_q <= CTRL_RST[BIT_WERR];
    end
    else if (wr_abort || (wr_attempt && !wr_allowed))
    begin
      werr_q <= 1'b1;
    end
    else if (wr_start)
    begin
      werr_q <= 1'b0; // Cleared as soon as an allowed write starts
    end
    else if (ctrl_wr)
    begin
      werr_q <= reg_wdata[BIT_WERR];
    end
  end

  // ****************************************************************
  // Self-timed write or erase cycle
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ws_q          <= WS_IDLE;
      wr_q          <= 1'b0;
      wcnt_q        <= 16'h0000;
      prog_busy_q   <= 1'b0;
      prog_target_q <= TGT_EEPROM;
      prog_erase_q  <= 1'b0;
      prog_addr_q   <= 8'h00;
      prog_data_q   <= 8'h00;
      prog_commit_q <= 1'b0;
    end
    else
    begin
      prog_commit_q <= wr_finish;
      case (ws_q)
        WS_IDLE:
        begin
          if (wr_start)
          begin
            ws_q          <= WS_BUSY;
            wr_q          <= 1'b1;
            wcnt_q        <= 16'h0000;
            prog_busy_q   <= 1'b1;
            prog_target_q <= cur_target;
            prog_erase_q  <= free_q;
            prog_addr_q   <= ee_addr_q;
            prog_data_q   <= ee_data_q;
          end
        end
        WS_BUSY:
        begin
          wcnt_q <= wcnt_q + 16'h0001;
          if (wr_finish || wr_abort)
          begin
            ws_q        <= WS_IDLE;
            wr_q        <= 1'b0;
            prog_busy_q <= 1'b0;
          end
        end
        default:
        begin
          ws_q <= WS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // One-cycle data EEPROM read by the processor
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_q      <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      rd_q      <= rd_start;
      rd_pend_q <= rd_start;
    end
  end

  // Address and data registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ee_addr_q <= 8'h00;
      ee_data_q <= 8'h00;
    end
    else
    begin
      if (reg_we && (reg_addr == OFS_ADDR))
      begin
        ee_addr_q <= reg_wdata;
      end
      if (rd_pend_q)
      begin
        ee_data_q <= mem_rdata;
      end
      else if (reg_we && (reg_addr == OFS_DATA))
      begin
        ee_data_q <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // External access answers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_rd_pend_q <= 1'b0;
      ext_ack_q     <= 1'b0;
      ext_refused_q <= 1'b0;
      ext_rdata_q   <= 8'h00;
    end
    else
    begin
      ext_rd_pend_q <= ext_go && ext_rd && !ext_wr;
      ext_ack_q     <= ext_go;
      ext_refused_q <= ext_refuse;
      if (ext_rd_pend_q)
      begin
        ext_rdata_q <= mem_rdata;
      end
    end
  end

  // ****************************************************************
  // Interrupt status, mask and output
  // ****************************************************************
  always_comb
  begin
    ev_set              = 8'h00;
    ev_set[EV_DONE]     = wr_finish;
    ev_set[EV_ERR]      = wr_abort || (wr_attempt && !wr_allowed);
    ev_set[EV_REFUSED]  = ext_refuse;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sts_q <= 8'h00;
      msk_q <= MSK_RST;
    end
    else
    begin
      if (reg_we && (reg_addr == OFS_IRQ_STS))
      begin
        sts_q <= (sts_q & ~reg_wdata) | ev_set; // Set wins over clear
      end
      else
      begin
        sts_q <= sts_q | ev_set;
      end
      if (reg_we && (reg_addr == OFS_IRQ_MSK))
      begin
        msk_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(sts_q & msk_q);
    end
  end

  // ****************************************************************
  // Register read port, data one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata_q <= 8'h00;
    end
    else if (reg_re)
    begin
      if (reg_addr == OFS_CTRL)
      begin
        reg_rdata_q <= {space_q, cfg_q, 1'b0, free_q, werr_q, wen_q, wr_q, rd_q};
      end
      else if (reg_addr == OFS_ADDR)
      begin
        reg_rdata_q <= ee_addr_q;
      end
      else if (reg_addr == OFS_DATA)
      begin
        reg_rdata_q <= ee_data_q;
      end
      else if (reg_addr == OFS_IRQ_STS)
      begin
        reg_rdata_q <= sts_q;
      end
      else if (reg_addr == OFS_IRQ_MSK)
      begin
        reg_rdata_q <= msk_q;
      end
      else
      begin
        reg_rdata_q <= 8'h00; // Key register and unmapped read zero
      end
    end
    else
    begin
      reg_rdata_q <= 8'h00;
    end
  end

endmodule

// *** design/nvac_pkg.sv ***
package nvac_pkg;

  // ****************************************************************
  // Register offsets on the software port
  // ****************************************************************
  localparam logic [3:0] OFS_CTRL    = 4'h0; // memory_control
  localparam logic [3:0] OFS_KEY     = 4'h1; // unlock_key_register
  localparam logic [3:0] OFS_ADDR    = 4'h2; // Data EEPROM address
  localparam logic [3:0] OFS_DATA    = 4'h3; // Data EEPROM data
  localparam logic [3:0] OFS_IRQ_STS = 4'h4; // Sticky event bits
  localparam logic [3:0] OFS_IRQ_MSK = 4'h5; // Event mask

  // ****************************************************************
  // memory_control field positions
  // ****************************************************************
  localparam int BIT_SPACE = 7; // memory_space_select
  localparam int BIT_CFG   = 6; // config_space_select
  localparam int BIT_FREE  = 4; // Erase instead of write
  localparam int BIT_WERR  = 3; // write_error_flag
  localparam int BIT_WEN   = 2; // write_enable_gate
  localparam int BIT_WR    = 1; // Write trigger
  localparam int BIT_RD    = 0; // Read trigger

  // ****************************************************************
  // Event bit positions and reset values
  // ****************************************************************
  localparam int EV_DONE    = 0; // Write cycle finished
  localparam int EV_ERR     = 1; // Write refused or aborted
  localparam int EV_REFUSED = 2; // External access refused
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MSK_RST  = 8'h00;

  // ****************************************************************
  // Unlock key values
  // ****************************************************************
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ       = 40;
  localparam int WRITE_TIME_NS = 4000;  // Self-timed write or erase
  localparam int WRITE_CYCLES  = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PWRT_TIME_US  = 64000; // powerup_timer_period
  localparam int PWRT_CYCLES   = PWRT_TIME_US * CLK_MHZ;

  // ****************************************************************
  // Access targets and state machines
  // ****************************************************************
  typedef enum logic [1:0] {
    TGT_EEPROM = 2'b00,
    TGT_FLASH  = 2'b01,
    TGT_CONFIG = 2'b10
  } nvac_target_t;

  typedef enum logic [1:0] {
    UNL_IDLE  = 2'b00,
    UNL_GOT1  = 2'b01,
    UNL_ARMED = 2'b10
  } nvac_unlock_t;

  typedef enum logic [0:0] {
    WS_IDLE = 1'b0,
    WS_BUSY = 1'b1
  } nvac_wstate_t;

endpackage

// *** design/nvac_mem.sv ***
`timescale 1ns/1ps
module nvac_mem
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       we,
  input  wire logic       re,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata_q
);

  logic [7:0] cells [0:255];

  // ****************************************************************
  // Array write, no reset on the cells
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      cells[addr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
    end
    else if (re)
    begin
      rdata_q <= cells[addr];
    end
  end

endmodule

// *** bench/nvac_chk_sva.sv ***
`timescale 1ns/1ps
module nvac_chk
  import nvac_pkg::*;
#(
  parameter int unsigned PWRT_COUNT = nvac_pkg::PWRT_CYCLES
)
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       dev_reset,
  input wire logic       cp_enable,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       ext_rd,
  input wire logic       ext_wr,
  input wire logic       ext_ack_q,
  input wire logic       ext_refused_q,
  input wire logic       prog_busy_q,
  input wire logic [1:0] prog_target_q,
  input wire logic       prog_commit_q,
  input wire logic       irq_q
);
  logic [31:0] pwrt_cnt_q;
  logic [15:0] busy_len_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Cycles since power-on reset, saturating at the timer length
  always_ff @(posedge clk)
  begin
    if (rst)
      pwrt_cnt_q <= 32'h0;
    else if (pwrt_cnt_q < PWRT_COUNT)
      pwrt_cnt_q <= pwrt_cnt_q + 32'h1;
  end

  // Length of the running self-timed cycle
  always_ff @(posedge clk)
  begin
    if (rst || !prog_busy_q)
      busy_len_q <= 16'h0;
    else
      busy_len_q <= busy_len_q + 16'h1;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  AST_START_CAUSE:
    assert property ($rose(prog_busy_q) |->
      $past(reg_we && reg_addr == OFS_CTRL && reg_wdata[BIT_WR]))
      else $error("Write cycle began without a trigger write");
  AST_PWRT_GUARD:
    assert property ($rose(prog_busy_q) && prog_target_q == TGT_EEPROM |->
      pwrt_cnt_q >= PWRT_COUNT)
      else $error("EEPROM write began inside the power-up timer");
  AST_BUSY_LEN:
    assert property ($fell(prog_busy_q) && !$past(dev_reset) |->
      busy_len_q >= WRITE_CYCLES - 2 && busy_len_q <= WRITE_CYCLES + 2)
      else $error("Self-timed cycle has the wrong length");
  AST_COMMIT:
    assert property ($fell(prog_busy_q) && !$past(dev_reset) |-> ##[0:1] prog_commit_q)
      else $error("No commit pulse after a normal finish");
  AST_COMMIT_PULSE:
    assert property (prog_commit_q |=> !prog_commit_q)
      else $error("Commit pulse longer than one cycle");
  AST_ABORT:
    assert property (prog_busy_q && dev_reset |=> !prog_busy_q && !prog_commit_q ##1 !prog_commit_q)
      else $error("Reset did not abort the write cleanly");
  AST_CP_REFUSE:
    assert property ((ext_rd || ext_wr) && cp_enable |=> ext_refused_q && !ext_ack_q)
      else $error("External access not refused under code protect");
  AST_ACK_CAUSE:
    assert property (ext_ack_q |-> $past((ext_rd || ext_wr) && !cp_enable))
      else $error("External access accepted without cause");
  AST_RST_QUIET:
    assert property ($fell(rst) |-> !prog_busy_q && !irq_q && reg_rdata_q == 8'h00)
      else $error("Outputs not quiet after power-on reset");
endmodule

bind nvac_top nvac_chk #(.PWRT_COUNT(PWRT_COUNT)) u_nvac_chk
(
  .clk(clk), .rst(rst), .dev_reset(dev_reset), .cp_enable(cp_enable),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata_q(reg_rdata_q),
  .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_ack_q(ext_ack_q), .ext_refused_q(ext_refused_q),
  .prog_busy_q(prog_busy_q), .prog_target_q(prog_target_q),
  .prog_commit_q(prog_commit_q), .irq_q(irq_q)
);

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import nvac_pkg::*;
  localparam int unsigned PWRT = 20;
  logic       clk, rst, dev_reset, cp_enable, reg_we, reg_re, ext_rd, ext_wr;
  logic       ext_ack_q, ext_refused_q, prog_busy_q, prog_erase_q, prog_commit_q, irq_q;
  logic [3:0] reg_addr;
  logic [1:0] prog_target_q;
  logic [7:0] reg_wdata, ext_addr, ext_wdata, reg_rdata_q, ext_rdata_q, prog_addr_q;
  logic [7:0] prog_data_q, a, v, t, m;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic       rd_seen;
  int         error_cnt, check_count, cyc;

  nvac_top #(.PWRT_COUNT(PWRT)) dut
  (
    .clk(clk), .rst(rst), .dev_reset(dev_reset), .cp_enable(cp_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata_q(reg_rdata_q), .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata_q(ext_rdata_q), .ext_ack_q(ext_ack_q),
    .ext_refused_q(ext_refused_q), .prog_busy_q(prog_busy_q), .prog_target_q(prog_target_q),
    .prog_erase_q(prog_erase_q), .prog_commit_q(prog_commit_q), .prog_addr_q(prog_addr_q),
    .prog_data_q(prog_data_q), .irq_q(irq_q)
  );

  // ****************************************************************
  // Clock, timeout and read monitor
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) rd_seen <= reg_re;
  always @(negedge clk)
  begin
    if (rd_seen === 1'b1)
    begin
      m = msk_q.pop_front();
      check(reg_rdata_q & m, exp_q.pop_front());
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // Queue the expected value; the monitor compares it
  task automatic rd(input logic [3:0] ad, input logic [7:0] e, input logic [7:0] mk);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_re <= 1'b0;
    exp_q.push_back(e);
    msk_q.push_back(mk);
  endtask

  task automatic unlock(input logic [7:0] ctl);
    wr(OFS_KEY, KEY_FIRST);
    wr(OFS_KEY, KEY_SECOND);
    wr(OFS_CTRL, ctl);
    repeat (2) @(negedge clk);
  endtask

  task automatic ext(input logic r, input logic [7:0] ad, input logic [7:0] d, input logic ok);
    @(posedge clk);
    ext_rd <= r;
    ext_wr <= !r;
    ext_addr <= ad;
    ext_wdata <= d;
    @(posedge clk);
    ext_rd <= 1'b0;
    ext_wr <= 1'b0;
    @(negedge clk);
    check({6'h00, ext_ack_q, ext_refused_q}, ok ? 8'h02 : 8'h01);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (prog_busy_q !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    check({7'h00, prog_busy_q}, 8'h00);
  endtask

  task automatic conclude();
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {rst, dev_reset, cp_enable, reg_we, reg_re, ext_rd, ext_wr} = 7'h40;
    {reg_addr, reg_wdata, ext_addr, ext_wdata} = 28'h0;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    void'($urandom(32'hB6371FB2));
    a = 8'($urandom_range(255));
    v = 8'($urandom_range(255));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, CTRL_RST, 8'hFF);
    rd(OFS_IRQ_MSK, MSK_RST, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    // Proper sequence still refused inside the power-up timer
    wr(OFS_CTRL, 8'h04);
    unlock(8'h06);
    check({7'h00, prog_busy_q}, 8'h00);
    rd(OFS_CTRL, 8'h0C, 8'h0E);
    repeat (PWRT) @(posedge clk);
    // Missing enable, missing key, keys in the wrong order
    for (int k = 0; k < 3; k++)
    begin
      wr(OFS_IRQ_STS, 8'hFF);
      wr(OFS_CTRL, (k == 0) ? 8'h00 : 8'h04);
      if (k == 0)
        unlock(8'h02);
      else if (k == 2)
      begin
        wr(OFS_KEY, KEY_SECOND);
        wr(OFS_KEY, KEY_FIRST);
      end
      wr(OFS_CTRL, (k == 0) ? 8'h02 : 8'h06);
      repeat (2) @(negedge clk);
      check({7'h00, prog_busy_q}, 8'h00);
      rd(OFS_IRQ_STS, 8'h02, 8'h02);
    end
    // Interrupt follows status and mask
    check({7'h00, irq_q}, 8'h00);
    wr(OFS_IRQ_MSK, 8'h02);
    repeat (2) @(negedge clk);
    check({7'h00, irq_q}, 8'h01);
    wr(OFS_IRQ_STS, 8'h02);
    repeat (2) @(negedge clk);
    check({7'h00, irq_q}, 8'h00);
    // Proper EEPROM write under code protect
    @(posedge clk);
    cp_enable <= 1'b1;
    wr(OFS_ADDR, a);
    wr(OFS_DATA, v);
    wr(OFS_CTRL, 8'h04);
    unlock(8'h06);
    check({prog_busy_q, 5'h00, prog_target_q}, {1'b1, 5'h00, TGT_EEPROM});
    check(prog_data_q, v);
    check(prog_addr_q, a);
    rd(OFS_CTRL, 8'h06, 8'h0E);
    wr(OFS_CTRL, 8'h04);
    rd(OFS_CTRL, 8'h02, 8'h02);
    wait_idle();
    rd(OFS_CTRL, 8'h04, 8'h0E);
    rd(OFS_IRQ_STS, 8'h01, 8'h01);
    // Internal read back, then a read that the space bit blocks
    wr(OFS_DATA, ~v);
    wr(OFS_CTRL, 8'h05);
    @(posedge clk);
    rd(OFS_DATA, v, 8'hFF);
    wr(OFS_DATA, ~v);
    wr(OFS_CTRL, 8'h84);
    wr(OFS_CTRL, 8'h85);
    @(posedge clk);
    rd(OFS_DATA, ~v, 8'hFF);
    rd(OFS_CTRL, 8'h80, 8'hC1);
    // External access refused, then accepted
    wr(OFS_IRQ_STS, 8'hFF);
    ext(1'b0, a, ~v, 1'b0);
    ext(1'b1, a, 8'h00, 1'b0);
    rd(OFS_IRQ_STS, 8'h04, 8'h04);
    cp_enable <= 1'b0;
    ext(1'b1, a, 8'h00, 1'b1);
    @(negedge clk);
    check(ext_rdata_q, v);
    // Flash and configuration targets; reset aborts the last
    for (int k = 0; k < 3; k++)
    begin
      t = (k == 0) ? 8'h90 : (k == 1) ? 8'hC0 : 8'h40;
      wr(OFS_CTRL, t | 8'h04);
      unlock(t | 8'h06);
      check({6'h00, prog_target_q}, {6'h00, (k == 0) ? TGT_FLASH : TGT_CONFIG});
      check({7'h00, prog_erase_q}, {7'h00, t[BIT_FREE]});
      if (k == 2)
      begin
        @(posedge clk);
        dev_reset <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        dev_reset <= 1'b0;
        rd(OFS_CTRL, t | 8'h08, 8'hCE);
      end
      wait_idle();
    end
    repeat (3) @(negedge clk);
    conclude();
  end
endmodule
